// [inc/swpc_defs.svh]
// constants of the sleep and wake power control block
`ifndef SWPC_DEFS_SVH
`define SWPC_DEFS_SVH
`define SWPC_POWER_CONTROL_ADDR 8'h87
`define SWPC_AUX_ADDR 8'h8E
`define SWPC_IE_ADDR 8'hA8
`define SWPC_TCON_ADDR 8'h88
`define SWPC_SERIAL_CONTROL_REG_ADDR 8'h98
`define SWPC_STAT_ADDR 8'hF0
`define SWPC_CFG_ADDR 8'hF1
`define SWPC_POWER_CONTROL_RESET 8'h00
`define SWPC_BIT_LIGHT 0
`define SWPC_BIT_DEEP 1
`define SWPC_BIT_GF0 2
`define SWPC_BIT_GF1 3
`define SWPC_BIT_LOSS 4
`define SWPC_BIT_WTSEL 5
`define SWPC_BIT_FESEL 6
`define SWPC_BIT_BAUD2 7
`define SWPC_BIT_STROBE_OFF 0
`define SWPC_BIT_EXA_EN 0
`define SWPC_BIT_EXB_EN 2
`define SWPC_BIT_ITA 0
`define SWPC_BIT_ITB 2
`define SWPC_CLK_MHZ 25
`define SWPC_T16_US 16
`define SWPC_T512_US 512
`define SWPC_T1024_US 1024
`define SWPC_T2048_US 2048
`define SWPC_T4096_US 4096
`define SWPC_T16384_US 16384
`define SWPC_RST_PULSE 2
`define SWPC_CNT_W 19
`endif

// [inc/swpc_pkg.sv]
// types of the sleep and wake power control block
package swpc_pkg;
    typedef enum logic [2:0] {
        RUN, LIGHT, DEEP, WAKE_TIMED, WAKE_PIN, WAKE_RESET, PULSE
    } state_type;
    typedef struct packed {
        logic cpuClkEn;
        logic periphClkEn;
        logic wdogClkEn;
        logic oscEn;
        logic dipDetEn;
        logic flashEn;
        logic portHold;
        logic cpuReset;
    } power_type;
    typedef struct packed {
        logic baudDouble;
        logic frameErrView;
        logic strobeOff;
    } serial_type;
endpackage

// [sim/swpc_top_props.sv]
// assertion checker for the sleep and wake power control block
`timescale 1ns/1ps
`include "swpc_defs.svh"
module swpc_top_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [31:0] avsReaddata,
    input wire logic avsWaitrequest,
    input wire logic avsResponseErr,
    input wire logic resetPin,
    input wire logic resetSenseSelect,
    input wire logic watchdogSleepRun,
    input wire logic frameErrorFlag,
    input wire logic serialModeBit,
    input wire swpc_pkg::power_type power,
    input wire swpc_pkg::serial_type serial,
    input wire logic serialCtrlBit7,
    input wire logic addrStrobeEn
);
    wire logic wrDone = avsWrite && !avsWaitrequest;
    wire logic mapped = avsAddress inside {`SWPC_POWER_CONTROL_ADDR, `SWPC_AUX_ADDR,
        `SWPC_IE_ADDR, `SWPC_TCON_ADDR, `SWPC_SERIAL_CONTROL_REG_ADDR, `SWPC_STAT_ADDR,
        `SWPC_CFG_ADDR};
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence twoCyclePulse;
        power.cpuReset [*2] ##1 !power.cpuReset;
    endsequence
    chk_deep_off:
    assert property (!power.oscEn |-> !power.dipDetEn && !power.flashEn
        && !power.cpuClkEn) else $error("deep sleep left a domain on");
    chk_gate_hold:
    assert property (!power.oscEn |=> !power.cpuClkEn)
        else $error("cpu clock ran straight out of deep sleep");
    chk_light_keeps:
    assert property (!power.cpuClkEn && power.periphClkEn && power.oscEn
        |-> power.dipDetEn && power.portHold
        && power.wdogClkEn == watchdogSleepRun)
        else $error("light sleep domains wrong");
    chk_wait_one:
    assert property ($rose(avsRead || avsWrite) |-> avsWaitrequest
        ##1 !avsWaitrequest) else $error("bus answer not after one wait");
    chk_unmapped_err:
    assert property (avsRead && !avsWaitrequest && !mapped |-> avsResponseErr
        && avsReaddata == 32'h0) else $error("unmapped read not refused");
    chk_strobe_write:
    assert property (wrDone && avsAddress == `SWPC_AUX_ADDR |=>
        addrStrobeEn == !$past(avsWritedata[0]))
        else $error("strobe enable not following strobe-off bit");
    chk_baud_write:
    assert property (wrDone && avsAddress == `SWPC_POWER_CONTROL_ADDR |=>
        {serial.baudDouble, serial.frameErrView} == $past(avsWritedata[7:6]))
        else $error("serial select bits not following write");
    chk_fe_view:
    assert property (serialCtrlBit7 == (serial.frameErrView ?
        frameErrorFlag : serialModeBit)) else $error("bit 7 view wrong");
    chk_reset_pulse:
    assert property ($rose(power.cpuReset) && resetPin != resetSenseSelect
        |-> twoCyclePulse) else $error("wake reset not two cycles");
endmodule // swpc_top_props
bind swpc_top swpc_top_props chk (.clk(clk), .reset(reset),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .avsResponseErr(avsResponseErr),
    .resetPin(resetPin), .resetSenseSelect(resetSenseSelect),
    .watchdogSleepRun(watchdogSleepRun), .frameErrorFlag(frameErrorFlag),
    .serialModeBit(serialModeBit), .power(power), .serial(serial),
    .serialCtrlBit7(serialCtrlBit7), .addrStrobeEn(addrStrobeEn));

// [sim/swpc_top_tb.sv]
// self-checking bench for the sleep and wake power control block
`timescale 1ns/1ps
`include "swpc_defs.svh"
module swpc_top_tb;
    typedef struct packed {
        logic [7:0] addr, wdata, mask;
        logic ferr, smode;
        logic [2:0] ser;
        logic strobeEn, bit7;
    } swpc_row_type;
    logic clk, reset, coldPowerUp, avsRead, avsWrite, avsWaitrequest;
    logic [7:0] avsAddress;
    logic [31:0] avsWritedata, avsReaddata, rdata;
    logic avsResponseErr, rerr, resetSenseSelect, periphIrq, cpuRetire;
    logic watchdogSleepRun, frameErrorFlag, serialModeBit, serialCtrlBit7;
    logic addrStrobeEn, irqAWake, irqBWake, extIrqAPin, extIrqBPin, resetPin;
    logic [2:0] fire;
    logic [15:0] lowCycles;
    swpc_pkg::power_type power;
    swpc_pkg::serial_type serial;
    int errors, samplesChecked, cycles, n;
    swpc_row_type rows [6];
    wire logic [5:0] lightView = {power.cpuClkEn, power.periphClkEn,
        power.wdogClkEn, power.oscEn, power.dipDetEn, power.portHold};
    wire logic [3:0] deepView = {power.cpuClkEn, power.oscEn,
        power.dipDetEn, power.flashEn};
    swpc_top uut (.clk(clk), .reset(reset), .coldPowerUp(coldPowerUp),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .avsResponseErr(avsResponseErr),
        .extIrqAPin(extIrqAPin), .extIrqBPin(extIrqBPin), .resetPin(resetPin),
        .resetSenseSelect(resetSenseSelect), .periphIrq(periphIrq),
        .watchdogSleepRun(watchdogSleepRun), .startupFuse(2'b00),
        .crystalSource(1'b0), .frameErrorFlag(frameErrorFlag),
        .serialModeBit(serialModeBit), .cpuRetire(cpuRetire), .power(power),
        .serial(serial), .serialCtrlBit7(serialCtrlBit7),
        .addrStrobeEn(addrStrobeEn), .irqAWake(irqAWake),
        .irqBWake(irqBWake));
    swpc_wake_source src (.clk(clk), .fire(fire), .lowCycles(lowCycles),
        .senseHigh(resetSenseSelect), .extIrqAPin(extIrqAPin),
        .extIrqBPin(extIrqBPin), .resetPin(resetPin));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic access(input logic wr, input logic [7:0] a,
            input logic [7:0] d);
        int w;
        avsAddress <= a;
        avsWritedata <= {24'h000000, d};
        avsWrite <= wr;
        avsRead <= !wr;
        w = 0;
        @(posedge clk);
        while (avsWaitrequest !== 1'b0 && w < 50) begin
            w++;
            @(posedge clk);
        end
        rdata = avsReaddata;
        rerr = avsResponseErr;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge clk);
    endtask
    task automatic sleep(input logic [7:0] v);
        access(1'b1, `SWPC_POWER_CONTROL_ADDR, v);
        cpuRetire <= 1'b1;
        @(posedge clk);
        cpuRetire <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic pulse(input logic [2:0] which, input logic [15:0] len);
        fire <= which;
        lowCycles <= len;
        @(posedge clk);
        fire <= 3'h0;
    endtask
    // bounded wait for the cpu clock (sel 0) or the cpu reset (sel 1)
    task automatic waitFor(input logic sel, input logic lvl, input int lim);
        n = 0;
        while ((sel ? power.cpuReset : power.cpuClkEn) !== lvl && n < lim)
        begin
            n++;
            @(posedge clk);
        end
    endtask
    task automatic finishTest();
        $display("comparisons %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            errors++;
            finishTest();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rows = '{'{8'h87, 8'h8C, 8'hFF, 1'b0, 1'b1, 3'h4, 1'b1, 1'b1},
            '{8'h87, 8'h4C, 8'hFF, 1'b1, 1'b0, 3'h2, 1'b1, 1'b1},
            '{8'h8E, 8'h01, 8'h00, 1'b0, 1'b1, 3'h3, 1'b0, 1'b0},
            '{8'h8E, 8'h00, 8'h00, 1'b1, 1'b1, 3'h2, 1'b1, 1'b1},
            '{8'h87, 8'h00, 8'hFF, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0},
            '{8'hF1, 8'hA5, 8'hFF, 1'b0, 1'b0, 3'h0, 1'b1, 1'b0}};
        reset = 1'b1;
        {coldPowerUp, avsRead, avsWrite, periphIrq, cpuRetire} = 5'h00;
        {watchdogSleepRun, frameErrorFlag, serialModeBit} = 3'h0;
        resetSenseSelect = 1'b1;
        avsAddress = 8'h00;
        avsWritedata = 32'h0;
        fire = 3'h0;
        lowCycles = 16'h0000;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        access(1'b0, `SWPC_POWER_CONTROL_ADDR, 8'h00);
        check("power control reset", rdata & 32'hEF,
            `SWPC_POWER_CONTROL_RESET);
        access(1'b0, 8'hF5, 8'h00);
        check("unmapped data", rdata, 32'h0);
        check("unmapped error", 32'(rerr), 32'h1);
        coldPowerUp <= 1'b1;
        @(posedge clk);
        coldPowerUp <= 1'b0;
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        access(1'b0, `SWPC_POWER_CONTROL_ADDR, 8'h00);
        check("loss flag", rdata, 32'h10);
        $display("test reset and loss flag done");
        foreach (rows[i]) begin
            frameErrorFlag <= rows[i].ferr;
            serialModeBit <= rows[i].smode;
            access(1'b1, rows[i].addr, rows[i].wdata);
            access(1'b0, rows[i].addr, 8'h00);
            check("readback", rdata & 32'(rows[i].mask),
                32'(rows[i].wdata & rows[i].mask));
            check("serial", 32'(serial), 32'(rows[i].ser));
            check("strobe", 32'(addrStrobeEn), 32'(rows[i].strobeEn));
            check("bit 7", 32'(serialCtrlBit7), 32'(rows[i].bit7));
        end
        $display("test register table done");
        sleep(8'h01);
        check("light domains", 32'(lightView), 32'h17);
        access(1'b0, `SWPC_STAT_ADDR, 8'h00);
        check("light state", rdata, 32'h1);
        periphIrq <= 1'b1;
        waitFor(1'b0, 1'b1, 20);
        periphIrq <= 1'b0;
        check("light wake", 32'(power.cpuClkEn), 32'h1);
        access(1'b0, `SWPC_POWER_CONTROL_ADDR, 8'h00);
        check("light bit cleared", rdata, 32'h0);
        $display("test light sleep done");
        access(1'b1, `SWPC_IE_ADDR, 8'h05);
        access(1'b1, `SWPC_TCON_ADDR, 8'h00);
        sleep(8'h22);
        check("deep domains", 32'(deepView), 32'h0);
        pulse(3'h1, 16'h0003);
        waitFor(1'b0, 1'b1, 600);
        check("timed wake", 32'(n >= 400 && n <= 412), 32'h1);
        check("wake a", 32'(irqAWake), 32'h1);
        access(1'b0, `SWPC_POWER_CONTROL_ADDR, 8'h00);
        check("deep bit cleared", rdata, 32'h20);
        sleep(8'h02);
        pulse(3'h2, 16'h0258);
        repeat (500) @(posedge clk);
        check("gated while low", 32'(power.cpuClkEn), 32'h0);
        waitFor(1'b0, 1'b1, 200);
        check("pin wake", 32'(n >= 100 && n <= 112), 32'h1);
        check("wake b", 32'(irqBWake), 32'h1);
        $display("test deep sleep pin wake done");
        access(1'b1, `SWPC_TCON_ADDR, 8'h01);
        sleep(8'h03);
        access(1'b0, `SWPC_STAT_ADDR, 8'h00);
        check("deep wins", rdata, 32'h2);
        pulse(3'h1, 16'h0003);
        repeat (450) @(posedge clk);
        check("edge mode stays", 32'(power.cpuClkEn), 32'h0);
        pulse(3'h4, 16'h0005);
        waitFor(1'b1, 1'b1, 600);
        check("reset wake", 32'(n >= 400 && n <= 420), 32'h1);
        waitFor(1'b1, 1'b0, 10);
        check("reset pulse", 32'(n), 32'h2);
        $display("test reset wake done");
        finishTest();
    end
endmodule // swpc_top_tb

// [sim/swpc_wake_source.sv]
// model of the external wake and reset sources
`timescale 1ns/1ps
module swpc_wake_source (
    input wire logic clk,
    input wire logic [2:0] fire,
    input wire logic [15:0] lowCycles,
    input wire logic senseHigh,
    output logic extIrqAPin,
    output logic extIrqBPin,
    output logic resetPin
);
    logic [15:0] cnt_q = 16'h0000;
    logic [2:0] sel_q = 3'h0;
    always @(posedge clk) begin
        if (fire != 3'h0) begin
            sel_q <= fire;
            cnt_q <= lowCycles;
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end
    // irq pins pulled up, reset pin idle at the inverse of senseHigh, each driven active only for the requested span
    wire logic active = cnt_q != 16'h0000;
    assign extIrqAPin = !(active && sel_q[0]);
    assign extIrqBPin = !(active && sel_q[1]);
    assign resetPin = (active && sel_q[2]) ? senseHigh : !senseHigh;
endmodule // swpc_wake_source

// [src/swpc_top.sv]
// sleep and wake power control with avalon register slave
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "swpc_defs.svh"
module swpc_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic coldPowerUp,
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    output logic avsResponseErr,
    input wire logic extIrqAPin,
    input wire logic extIrqBPin,
    input wire logic resetPin,
    input wire logic resetSenseSelect,
    input wire logic periphIrq,
    input wire logic watchdogSleepRun,
    input wire logic [1:0] startupFuse,
    input wire logic crystalSource,
    input wire logic frameErrorFlag,
    input wire logic serialModeBit,
    input wire logic cpuRetire,
    output swpc_pkg::power_type power,
    output swpc_pkg::serial_type serial,
    output logic serialCtrlBit7,
    output logic addrStrobeEn,
    output logic irqAWake,
    output logic irqBWake
);
    // --------------------------------------------------------------
    // timing counts
    // --------------------------------------------------------------
    localparam int C16 = `SWPC_T16_US * `SWPC_CLK_MHZ;
    localparam int C512 = `SWPC_T512_US * `SWPC_CLK_MHZ;
    localparam int C1024 = `SWPC_T1024_US * `SWPC_CLK_MHZ;
    localparam int C2048 = `SWPC_T2048_US * `SWPC_CLK_MHZ;
    localparam int C4096 = `SWPC_T4096_US * `SWPC_CLK_MHZ;
    localparam int C16384 = `SWPC_T16384_US * `SWPC_CLK_MHZ;

    function automatic logic [`SWPC_CNT_W-1:0] timeout(
        input logic [1:0] fuse, input logic xtal);
        int c;
        case (fuse)
            2'h0: c = xtal ? C1024 : C16;
            2'h1: c = xtal ? C2048 : C512;
            2'h2: c = xtal ? C4096 : C1024;
            default: c = xtal ? C16384 : C4096;
        endcase
        return c[`SWPC_CNT_W-1:0];
    endfunction

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [2:0] syncA_q, syncB_q, syncR_q;
    logic pinA_q, pinB_q, pinR_q, polS_q, pol_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            syncA_q <= 3'h7;
            syncB_q <= 3'h7;
            syncR_q <= 3'h0;
        end else begin
            syncA_q <= {syncA_q[1:0], extIrqAPin};
            syncB_q <= {syncB_q[1:0], extIrqBPin};
            syncR_q <= {syncR_q[1:0], resetPin};
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pinA_q <= 1'b1;
            pinB_q <= 1'b1;
            pinR_q <= 1'b0;
            polS_q <= 1'b1;
            pol_q <= 1'b1;
        end else begin
            // one stage behind the synchroniser output, for edge detection
            pinA_q <= syncA_q[2];
            pinB_q <= syncB_q[2];
            pinR_q <= syncR_q[2];
            polS_q <= resetSenseSelect;
            pol_q <= polS_q;
        end
    end
    wire logic aLow = ~pinA_q;
    wire logic bLow = ~pinB_q;
    wire logic aFall = pinA_q & ~syncA_q[2];
    wire logic bFall = pinB_q & ~syncB_q[2];
    wire logic aRise = ~pinA_q & syncA_q[2];
    wire logic bRise = ~pinB_q & syncB_q[2];
    // reset pin level translated to active sense
    wire logic rstAct = pinR_q ~^ pol_q;
    wire logic rstNow = syncR_q[2] ~^ pol_q;
    wire logic rstRel = rstAct & ~rstNow;

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    logic [7:0] power_control_q, power_control_d, aux_q, ie_q, tcon_q, cfg_q;
    logic lossSeen_q;
    swpc_pkg::state_type state_q, state_d;
    logic [`SWPC_CNT_W-1:0] cnt_q, cnt_d;
    logic [1:0] pulse_q, pulse_d;
    logic wakeA_q, wakeB_q, wakeA_d, wakeB_d;
    logic [31:0] rdata_q;
    logic ack_q;

    wire logic req = (avsRead | avsWrite) & ~ack_q;
    wire logic selPcon = avsAddress == `SWPC_POWER_CONTROL_ADDR;
    wire logic selAux = avsAddress == `SWPC_AUX_ADDR;
    wire logic selIe = avsAddress == `SWPC_IE_ADDR;
    wire logic selTcon = avsAddress == `SWPC_TCON_ADDR;
    wire logic selScon = avsAddress == `SWPC_SERIAL_CONTROL_REG_ADDR;
    wire logic selStat = avsAddress == `SWPC_STAT_ADDR;
    wire logic selCfg = avsAddress == `SWPC_CFG_ADDR;
    wire logic mapped = selPcon | selAux | selIe | selTcon | selScon
        | selStat | selCfg;
    // write takes effect at the edge where waitrequest is low
    wire logic wrEdge = avsWrite & ack_q;
    wire logic wrPcon = wrEdge & selPcon;

    // permitted deep-sleep wake sources
    wire logic aArmed = ie_q[`SWPC_BIT_EXA_EN] & ~tcon_q[`SWPC_BIT_ITA];
    wire logic bArmed = ie_q[`SWPC_BIT_EXB_EN] & ~tcon_q[`SWPC_BIT_ITB];
    wire logic anyIrq = periphIrq | (ie_q[`SWPC_BIT_EXA_EN] & aLow)
        | (ie_q[`SWPC_BIT_EXB_EN] & bLow);
    wire logic wtSel = power_control_q[`SWPC_BIT_WTSEL];
    wire logic cntDone = cnt_q == '0;

    // --------------------------------------------------------------
    // sleep and wake sequencer
    // --------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        pulse_d = pulse_q;
        wakeA_d = wakeA_q;
        wakeB_d = wakeB_q;
        power_control_d = power_control_q;
        if (wrPcon) begin
            power_control_d = avsWritedata[7:0];
        end
        case (state_q)
            swpc_pkg::RUN: begin
                wakeA_d = 1'b0;
                wakeB_d = 1'b0;
                // deep wins when both are requested
                if (power_control_q[`SWPC_BIT_DEEP] & cpuRetire) begin
                    state_d = swpc_pkg::DEEP;
                    cnt_d = timeout(startupFuse, crystalSource);
                end else if (power_control_q[`SWPC_BIT_LIGHT] & cpuRetire) begin
                    state_d = swpc_pkg::LIGHT;
                end
            end
            swpc_pkg::LIGHT: begin
                if (anyIrq | rstAct) begin
                    state_d = swpc_pkg::RUN;
                    power_control_d[`SWPC_BIT_LIGHT] = 1'b0;
                end
            end
            swpc_pkg::DEEP: begin
                cnt_d = timeout(startupFuse, crystalSource);
                if (rstRel) begin
                    state_d = swpc_pkg::WAKE_RESET;
                end else if ((aArmed & aFall) | (bArmed & bFall)) begin
                    wakeA_d = aArmed & aFall;
                    wakeB_d = bArmed & bFall;
                    state_d = wtSel ? swpc_pkg::WAKE_TIMED
                        : swpc_pkg::WAKE_PIN;
                end
            end
            swpc_pkg::WAKE_TIMED: begin
                // pin level ignored here, the count alone ends it
                cnt_d = cntDone ? cnt_q : cnt_q - 1'b1;
                if (cntDone) begin
                    state_d = swpc_pkg::RUN;
                    power_control_d[`SWPC_BIT_DEEP] = 1'b0;
                    power_control_d[`SWPC_BIT_LIGHT] = 1'b0;
                end
            end
            swpc_pkg::WAKE_PIN: begin
                // the source is trusted to hold low until stable
                if ((wakeA_q & aRise) | (wakeB_q & bRise)) begin
                    state_d = swpc_pkg::RUN;
                    power_control_d[`SWPC_BIT_DEEP] = 1'b0;
                    power_control_d[`SWPC_BIT_LIGHT] = 1'b0;
                end
            end
            swpc_pkg::WAKE_RESET: begin
                cnt_d = cntDone ? cnt_q : cnt_q - 1'b1;
                if (cntDone & ~rstAct) begin
                    state_d = swpc_pkg::PULSE;
                    pulse_d = 2'(`SWPC_RST_PULSE - 1);
                end
                if (cntDone) begin
                    power_control_d[`SWPC_BIT_DEEP] = 1'b0;
                    power_control_d[`SWPC_BIT_LIGHT] = 1'b0;
                end
            end
            swpc_pkg::PULSE: begin
                pulse_d = pulse_q - 1'b1;
                if (pulse_q == 2'h0) begin
                    state_d = swpc_pkg::RUN;
                end
            end
            default: state_d = swpc_pkg::RUN;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= swpc_pkg::RUN;
            cnt_q <= '0;
            pulse_q <= 2'h0;
            wakeA_q <= 1'b0;
            wakeB_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pulse_q <= pulse_d;
            wakeA_q <= wakeA_d;
            wakeB_q <= wakeB_d;
        end
    end

    // loss flag kept apart from the power_control reset so warm resets keep it
    logic loss_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_control_q <= `SWPC_POWER_CONTROL_RESET;
        end else begin
            power_control_q <= power_control_d;
        end
    end
    always_ff @(posedge clk) begin
        if (coldPowerUp) begin
            loss_q <= 1'b1;
        end else if (wrPcon) begin
            loss_q <= avsWritedata[`SWPC_BIT_LOSS];
        end
    end
    // no reset here either: a warm reset must not hide the flag
    always_ff @(posedge clk) begin
        lossSeen_q <= lossSeen_q | coldPowerUp | wrPcon;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            aux_q <= 8'h00;
            ie_q <= 8'h00;
            tcon_q <= 8'h00;
            cfg_q <= 8'h00;
        end else begin
            if (wrEdge & selAux) aux_q <= avsWritedata[7:0];
            if (wrEdge & selIe) ie_q <= avsWritedata[7:0];
            if (wrEdge & selTcon) tcon_q <= avsWritedata[7:0];
            if (wrEdge & selCfg) cfg_q <= avsWritedata[7:0];
        end
    end

    // --------------------------------------------------------------
    // avalon slave: one wait cycle on every access
    // --------------------------------------------------------------
    wire logic [7:0] pconView = {power_control_q[7:5], loss_q & lossSeen_q,
        power_control_q[3:0]};
    wire logic [7:0] sconView = {serialCtrlBit7, 7'h00};
    wire logic [7:0] statView = {5'h00, state_q};
    wire logic [7:0] rdByte = selPcon ? pconView
        : selAux ? aux_q
        : selIe ? ie_q
        : selTcon ? tcon_q
        : selScon ? sconView
        : selStat ? statView
        : selCfg ? cfg_q
        : 8'h00;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
            avsResponseErr <= 1'b0;
        end else begin
            ack_q <= req;
            if (req) begin
                rdata_q <= {24'h000000, rdByte};
                avsResponseErr <= ~mapped;
            end
        end
    end
    assign avsReaddata = rdata_q;
    assign avsWaitrequest = (avsRead | avsWrite) & ~ack_q;

    // --------------------------------------------------------------
    // power outputs
    // --------------------------------------------------------------
    wire logic inLight = state_q == swpc_pkg::LIGHT;
    wire logic inDeep = state_q == swpc_pkg::DEEP;
    wire logic waking = state_q == swpc_pkg::WAKE_TIMED
        | state_q == swpc_pkg::WAKE_PIN | state_q == swpc_pkg::WAKE_RESET;
    assign power.cpuClkEn = state_q == swpc_pkg::RUN
        | state_q == swpc_pkg::PULSE;
    assign power.periphClkEn = ~inDeep & ~waking;
    assign power.wdogClkEn = inLight ? watchdogSleepRun : ~inDeep;
    assign power.oscEn = ~inDeep;
    assign power.dipDetEn = ~inDeep;
    assign power.flashEn = ~inDeep;
    assign power.portHold = ~power.cpuClkEn;
    assign power.cpuReset = state_q == swpc_pkg::PULSE
        | (state_q == swpc_pkg::WAKE_RESET & cntDone & rstAct);
    assign serial.baudDouble = power_control_q[`SWPC_BIT_BAUD2];
    assign serial.frameErrView = power_control_q[`SWPC_BIT_FESEL];
    assign serial.strobeOff = aux_q[`SWPC_BIT_STROBE_OFF];
    // flag itself is set elsewhere on any frame error
    assign serialCtrlBit7 = power_control_q[`SWPC_BIT_FESEL] ? frameErrorFlag
        : serialModeBit;
    assign addrStrobeEn = ~aux_q[`SWPC_BIT_STROBE_OFF];
    // handler request once the cpu clock runs again
    assign irqAWake = wakeA_q & state_q == swpc_pkg::RUN;
    assign irqBWake = wakeB_q & state_q == swpc_pkg::RUN;
endmodule // swpc_top
